/* File: inc/adc_ctrl_pkg.sv */
// Constants shared by the record-path digital control register group.
package adc_ctrl_pkg;

	localparam logic [7:0] ADDR_INSTR_MODE = 8'h3e;
	localparam logic [7:0] ADDR_RSVD_FIRST = 8'h3f;
	localparam logic [7:0] ADDR_RSVD_LAST = 8'h4f;
	localparam logic [7:0] ADDR_DMIC_POL = 8'h50;
	localparam logic [7:0] ADDR_DIG_CTRL = 8'h51;
	localparam logic [7:0] ADDR_FINE_MUTE = 8'h52;
	localparam logic [7:0] ADDR_LEFT_VOL = 8'h53;

	// Instruction-mode control fields.
	localparam int BIT_AUX_A = 6;
	localparam int BIT_AUX_B = 5;
	localparam int BIT_IC_RESET_OFF = 4;

	// Microphone polarity fields.
	localparam int BIT_POL_LEFT = 1;
	localparam int BIT_POL_RIGHT = 0;

	// Digital control fields.
	localparam int BIT_PWR_LEFT = 7;
	localparam int BIT_PWR_RIGHT = 6;
	localparam int BIT_PIN_LEFT = 5;
	localparam int BIT_PIN_RIGHT = 4;
	localparam int BIT_DMIC_LEFT = 3;
	localparam int BIT_DMIC_RIGHT = 2;
	localparam int BIT_STEP_HI = 1;
	localparam int BIT_STEP_LO = 0;

	// Fine-volume and mute fields.
	localparam int BIT_MUTE_LEFT = 7;
	localparam int BIT_FINE_LEFT_HI = 6;
	localparam int BIT_FINE_LEFT_LO = 4;
	localparam int BIT_MUTE_RIGHT = 3;
	localparam int BIT_FINE_RIGHT_HI = 2;
	localparam int BIT_FINE_RIGHT_LO = 0;

	localparam logic [7:0] RST_INSTR_MODE = 8'h00;
	localparam logic [7:0] RST_DMIC_POL = 8'h00;
	localparam logic [7:0] RST_DIG_CTRL = 8'h00;
	localparam logic [7:0] RST_FINE_MUTE = 8'h88;
	localparam logic [7:0] RST_LEFT_VOL = 8'h00;

	// Writable bits of the instruction-mode, polarity and left-volume registers; the rest read back as zero.
	localparam logic [7:0] MASK_INSTR_MODE = 8'h70;
	localparam logic [7:0] MASK_DMIC_POL = 8'h03;
	localparam logic [7:0] MASK_LEFT_VOL = 8'h7f;

	localparam logic [1:0] STEP_EVERY_FS = 2'h0;
	localparam logic [1:0] STEP_EVERY_2FS = 2'h1;
	localparam logic [1:0] STEP_DISABLED = 2'h2;

	localparam logic [2:0] FINE_MAX = 3'h4;
	localparam logic [6:0] VOL_MIN = 7'h68;
	localparam logic [6:0] VOL_MAX = 7'h28;
	localparam logic [4:0] PROG_MODE_SEL = 5'h00;

endpackage

/* File: hdl/dmic_capture.sv */
// One digital-microphone capture channel with edge and pin selection.
`timescale 1ns/10ps
`default_nettype none

module dmic_capture (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic mod_clk,
	input wire logic dmic_data_pin,
	input wire logic dmic_clock_pin,
	input wire logic fall_edge,
	input wire logic from_clock_pin,
	input wire logic enable,
	output logic sample_bit,
	output logic sample_valid
);

	typedef struct packed {
		logic mod_clk_d;
		logic bit_val;
		logic valid;
	} cap_state_t;

	cap_state_t st_ff;
	cap_state_t nxt_st;
	logic edge_hit;
	logic pin_val;

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		nxt_st = st_ff;
		nxt_st.mod_clk_d = mod_clk;
		edge_hit = fall_edge ? (st_ff.mod_clk_d & ~mod_clk) : (~st_ff.mod_clk_d & mod_clk);
		pin_val = from_clock_pin ? dmic_clock_pin : dmic_data_pin;
		nxt_st.valid = enable & edge_hit;
		if (enable & edge_hit) begin
			nxt_st.bit_val = pin_val;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sample_bit = st_ff.bit_val;
	assign sample_valid = st_ff.valid;

endmodule

`default_nettype wire

/* File: hdl/adc_channel_digital_control.sv */
// Record-path digital control registers, engine flags, microphone capture and volume ramp.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Writable auxiliary flag A in bit 6, seen by conditional jumps.
// - Writable auxiliary flag B in bit 5, seen by conditional jumps.
// - Bit 4 low clears the instruction counter at frame start; high keeps it.
// - Left microphone sampled on rising edge if bit 1 low, falling if high.
// - Right microphone sampled on rising edge if bit 0 low, falling if high.
// - Left channel powered up only while bit 7 is set.
// - Right channel powered up only while bit 6 is set.
// - Left microphone taken from data pin, or clock pin when bit 5 set.
// - Right microphone taken from data pin, or clock pin when bit 4 set.
// - Left channel uses the microphone only when bit 3 is set.
// - Right channel uses the microphone only when bit 2 is set.
// - Step field: 00 per sample, 01 per two samples, 10 no stepping.
// - Left channel muted while fine register bit 7 is set; reset muted.
// - Right channel muted while fine register bit 3 is set; reset muted.
// - Fine gain codes 0 to 4 attenuate 0.1 dB per step.
// - Left coarse volume is signed half-dB from -12 dB to +20 dB.
// - Flags and instruction counter apply only when block select is zero.
module adc_channel_digital_control
	import adc_ctrl_pkg::*;
#(
	parameter int INSTR_W = 9
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [4:0] proc_block_sel,
	input wire logic frame_start,
	input wire logic instr_step,
	input wire logic fs_tick,
	input wire logic [6:0] right_coarse_volume,
	input wire logic mod_clk,
	input wire logic dmic_data_pin,
	input wire logic dmic_clock_pin,
	output logic aux_flag_a,
	output logic aux_flag_b,
	output logic [INSTR_W-1:0] instr_count,
	output logic left_power_up,
	output logic right_power_up,
	output logic left_dmic_bit,
	output logic left_dmic_valid,
	output logic right_dmic_bit,
	output logic right_dmic_valid,
	output logic [6:0] left_gain,
	output logic [6:0] right_gain,
	output logic left_mute,
	output logic right_mute,
	output logic [2:0] left_fine,
	output logic [2:0] right_fine
);

	typedef struct packed {
		logic [7:0] instr_mode;
		logic [7:0] dmic_pol;
		logic [7:0] dig_ctrl;
		logic [7:0] fine_mute;
		logic [7:0] left_vol;
		logic [7:0] rdata;
		logic [INSTR_W-1:0] icount;
		logic aux_a_out;
		logic aux_b_out;
		logic [1:0][6:0] gain;
		logic [1:0] half_phase;
	} ctrl_state_t;

	ctrl_state_t st_ff;
	ctrl_state_t nxt_st;

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// A reserved fine code would exceed the defined range, so it is held at the largest step.
	function automatic logic [2:0] fine_clamp(input logic [2:0] code);
		logic [2:0] res;
		res = (code > FINE_MAX) ? FINE_MAX : code;
		return res;
	endfunction

	// Codes below the lowest defined step act as that step, codes above the top as the top.
	function automatic logic [6:0] vol_clamp(input logic [6:0] code);
		logic [6:0] res;
		res = code;
		if ($signed(code) < $signed(VOL_MIN)) begin
			res = VOL_MIN;
		end else if ($signed(code) > $signed(VOL_MAX)) begin
			res = VOL_MAX;
		end
		return res;
	endfunction

	function automatic logic [7:0] read_word(input ctrl_state_t s, input logic [7:0] addr);
		logic [7:0] res;
		res = 8'h00;
		case (addr)
			ADDR_INSTR_MODE: res = s.instr_mode;
			ADDR_DMIC_POL: res = s.dmic_pol;
			ADDR_DIG_CTRL: res = s.dig_ctrl;
			ADDR_FINE_MUTE: res = s.fine_mute;
			ADDR_LEFT_VOL: res = s.left_vol;
			default: res = 8'h00;
		endcase
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	logic prog_mode;
	logic [1:0][6:0] target;
	logic [1:0] powered;
	logic [1:0] step_mode;
	logic [7:0] fine_wr;

	always_comb begin
		nxt_st = st_ff;
		prog_mode = (proc_block_sel == PROG_MODE_SEL);
		powered[1] = st_ff.dig_ctrl[BIT_PWR_LEFT];
		powered[0] = st_ff.dig_ctrl[BIT_PWR_RIGHT];
		step_mode = st_ff.dig_ctrl[BIT_STEP_HI:BIT_STEP_LO];
		target[1] = vol_clamp(st_ff.left_vol[6:0]);
		target[0] = vol_clamp(right_coarse_volume);
		fine_wr = reg_wdata;
		fine_wr[BIT_FINE_LEFT_HI:BIT_FINE_LEFT_LO] =
			fine_clamp(reg_wdata[BIT_FINE_LEFT_HI:BIT_FINE_LEFT_LO]);
		fine_wr[BIT_FINE_RIGHT_HI:BIT_FINE_RIGHT_LO] =
			fine_clamp(reg_wdata[BIT_FINE_RIGHT_HI:BIT_FINE_RIGHT_LO]);

		// Register writes; reserved bits are masked so they always read zero.
		if (reg_wr) begin
			case (reg_addr)
				ADDR_INSTR_MODE: nxt_st.instr_mode = reg_wdata & MASK_INSTR_MODE;
				ADDR_DMIC_POL: nxt_st.dmic_pol = reg_wdata & MASK_DMIC_POL;
				ADDR_DIG_CTRL: nxt_st.dig_ctrl = reg_wdata;
				ADDR_FINE_MUTE: nxt_st.fine_mute = fine_wr;
				ADDR_LEFT_VOL: nxt_st.left_vol = reg_wdata & MASK_LEFT_VOL;
				default: nxt_st.rdata = nxt_st.rdata; // Reserved range takes no write.
			endcase
		end
		if (reg_rd) begin
			nxt_st.rdata = read_word(st_ff, reg_addr);
		end

		// Engine flags reach the jump logic only in programmable instruction mode.
		nxt_st.aux_a_out = prog_mode & st_ff.instr_mode[BIT_AUX_A];
		nxt_st.aux_b_out = prog_mode & st_ff.instr_mode[BIT_AUX_B];

		// Frame start outranks a step in the same cycle, so the frame begins at zero unless bit 4 keeps the count.
		if (!prog_mode) begin
			nxt_st.icount = '0;
		end else if (frame_start && !st_ff.instr_mode[BIT_IC_RESET_OFF]) begin
			nxt_st.icount = '0;
		end else if (instr_step) begin
			nxt_st.icount = st_ff.icount + 1'b1;
		end

		// Volume ramp for each channel; index 1 is left, index 0 is right.
		for (int ch = 0; ch < 2; ch++) begin
			if (!powered[ch] || step_mode[1]) begin
				// Powered-down channels and disabled stepping jump straight to the target.
				nxt_st.gain[ch] = target[ch];
				nxt_st.half_phase[ch] = 1'b0;
			end else if (fs_tick) begin
				nxt_st.half_phase[ch] = ~st_ff.half_phase[ch];
				if ((step_mode == STEP_EVERY_FS) || st_ff.half_phase[ch]) begin
					if ($signed(st_ff.gain[ch]) < $signed(target[ch])) begin
						nxt_st.gain[ch] = st_ff.gain[ch] + 7'h01;
					end else if ($signed(st_ff.gain[ch]) > $signed(target[ch])) begin
						nxt_st.gain[ch] = st_ff.gain[ch] - 7'h01;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.instr_mode <= RST_INSTR_MODE;
			st_ff.dmic_pol <= RST_DMIC_POL;
			st_ff.dig_ctrl <= RST_DIG_CTRL;
			st_ff.fine_mute <= RST_FINE_MUTE;
			st_ff.left_vol <= RST_LEFT_VOL;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Microphone capture, one instance per channel.

	dmic_capture u_cap_left (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.mod_clk(mod_clk),
		.dmic_data_pin(dmic_data_pin),
		.dmic_clock_pin(dmic_clock_pin),
		.fall_edge(st_ff.dmic_pol[BIT_POL_LEFT]),
		.from_clock_pin(st_ff.dig_ctrl[BIT_PIN_LEFT]),
		.enable(st_ff.dig_ctrl[BIT_DMIC_LEFT] & st_ff.dig_ctrl[BIT_PWR_LEFT]),
		.sample_bit(left_dmic_bit),
		.sample_valid(left_dmic_valid)
	);

	dmic_capture u_cap_right (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.mod_clk(mod_clk),
		.dmic_data_pin(dmic_data_pin),
		.dmic_clock_pin(dmic_clock_pin),
		.fall_edge(st_ff.dmic_pol[BIT_POL_RIGHT]),
		.from_clock_pin(st_ff.dig_ctrl[BIT_PIN_RIGHT]),
		.enable(st_ff.dig_ctrl[BIT_DMIC_RIGHT] & st_ff.dig_ctrl[BIT_PWR_RIGHT]),
		.sample_bit(right_dmic_bit),
		.sample_valid(right_dmic_valid)
	);

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all taken from state flops.

	assign reg_rdata = st_ff.rdata;
	assign aux_flag_a = st_ff.aux_a_out;
	assign aux_flag_b = st_ff.aux_b_out;
	assign instr_count = st_ff.icount;
	assign left_power_up = st_ff.dig_ctrl[BIT_PWR_LEFT];
	assign right_power_up = st_ff.dig_ctrl[BIT_PWR_RIGHT];
	assign left_gain = st_ff.gain[1];
	assign right_gain = st_ff.gain[0];
	assign left_mute = st_ff.fine_mute[BIT_MUTE_LEFT];
	assign right_mute = st_ff.fine_mute[BIT_MUTE_RIGHT];
	assign left_fine = st_ff.fine_mute[BIT_FINE_LEFT_HI:BIT_FINE_LEFT_LO];
	assign right_fine = st_ff.fine_mute[BIT_FINE_RIGHT_HI:BIT_FINE_RIGHT_LO];

endmodule

`default_nettype wire

/* File: verif/adc_ctrl_properties.sv */
// Port-level assertions for the record-path control registers.
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_properties
	import adc_ctrl_pkg::*;
#(
	parameter int INSTR_W = 9
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [4:0] proc_block_sel,
	input wire logic [INSTR_W-1:0] instr_count,
	input wire logic aux_flag_a,
	input wire logic aux_flag_b,
	input wire logic left_power_up,
	input wire logic right_power_up,
	input wire logic left_mute,
	input wire logic right_mute,
	input wire logic [2:0] left_fine,
	input wire logic [6:0] left_gain
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence wr_ctrl; reg_wr && reg_addr == ADDR_DIG_CTRL; endsequence
	sequence wr_fine; reg_wr && reg_addr == ADDR_FINE_MUTE; endsequence
	a_pwr_left: assert property (wr_ctrl |=> left_power_up == $past(reg_wdata[7]))
		else $error("left power does not follow its bit");
	a_pwr_right: assert property (wr_ctrl |=> right_power_up == $past(reg_wdata[6]))
		else $error("right power does not follow its bit");
	a_mute_left: assert property (wr_fine |=> left_mute == $past(reg_wdata[7]))
		else $error("left mute does not follow its bit");
	a_mute_right: assert property (wr_fine |=> right_mute == $past(reg_wdata[3]))
		else $error("right mute does not follow its bit");
	a_fine_left: assert property (wr_fine and (reg_wdata[6:4] <= FINE_MAX) |=>
		left_fine == $past(reg_wdata[6:4])) else $error("left fine gain not stored");
	a_flag_a_mode: assert property (aux_flag_a |->
		$past(proc_block_sel) == PROG_MODE_SEL)
		else $error("flag A seen outside instruction mode");
	a_flag_b_mode: assert property (aux_flag_b |->
		$past(proc_block_sel) == PROG_MODE_SEL)
		else $error("flag B seen outside instruction mode");
	a_count_idle: assert property (proc_block_sel != PROG_MODE_SEL |=>
		instr_count == 0)
		else $error("instruction counter runs outside instruction mode");
	a_gain_range: assert property ($signed(left_gain) >= -24 &&
		$signed(left_gain) <= 40)
		else $error("left gain outside its range");
endmodule
bind adc_channel_digital_control adc_ctrl_properties #(.INSTR_W(INSTR_W)) i_props (
	.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .proc_block_sel(proc_block_sel), .instr_count(instr_count),
	.aux_flag_a(aux_flag_a), .aux_flag_b(aux_flag_b), .left_power_up(left_power_up),
	.right_power_up(right_power_up), .left_mute(left_mute), .right_mute(right_mute),
	.left_fine(left_fine), .left_gain(left_gain));
`default_nettype wire

/* File: verif/host_bus_model.sv */
// Host controller model that writes and reads the control registers.
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
	input wire logic sys_clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
	end
	// Callers keep reserved fields at their reset values and never write the reserved
	// offsets. Released lines show the inverse, not a stale value.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

/* File: verif/test_adc_channel_digital_control.sv */
// Self-checking bench for the record-path control registers.
`timescale 1ns/10ps
`default_nettype none
module test_adc_channel_digital_control;
	import adc_ctrl_pkg::*;
	logic sys_clk = 1'b0, rst_n = 1'b0, frame_start = 1'b0, instr_step = 1'b0, fs_tick = 1'b0;
	logic mod_clk = 1'b0, dpin = 1'b0, cpin = 1'b0, reg_wr, reg_rd, aux_a, aux_b, lpw, rpw;
	logic lbit, lval, rbit, rval, lmute, rmute, lbit_seen = 1'b0, rbit_seen = 1'b0;
	logic [4:0] sel = 5'h00;
	logic [7:0] addr, wdata, rdata, lcnt = 8'h00, rcnt = 8'h00;
	logic [8:0] count;
	logic [6:0] lgain, rgain, rvol = 7'h00;
	logic [2:0] lfine, rfine;
	int bad_count = 0, checks = 0, cycles = 0;
	adc_channel_digital_control i_adc_channel_digital_control (.sys_clk(sys_clk),
		.rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(rdata), .proc_block_sel(sel), .frame_start(frame_start),
		.instr_step(instr_step), .fs_tick(fs_tick), .right_coarse_volume(rvol),
		.mod_clk(mod_clk), .dmic_data_pin(dpin), .dmic_clock_pin(cpin), .aux_flag_a(aux_a),
		.aux_flag_b(aux_b), .instr_count(count), .left_power_up(lpw), .right_power_up(rpw),
		.left_dmic_bit(lbit), .left_dmic_valid(lval), .right_dmic_bit(rbit),
		.right_dmic_valid(rval), .left_gain(lgain), .right_gain(rgain), .left_mute(lmute),
		.right_mute(rmute), .left_fine(lfine), .right_fine(rfine));
	host_bus_model i_host_bus_model (.sys_clk(sys_clk), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Valid is a one-cycle pulse, so captures are counted here rather than polled.
	always @(posedge sys_clk) begin
		cycles++;
		if (lval) {lcnt, lbit_seen} <= {lcnt + 8'h01, lbit};
		if (rval) {rcnt, rbit_seen} <= {rcnt + 8'h01, rbit};
		if (cycles == 3000) begin
			bad_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t port %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host_bus_model.rd(a, d);
		chk_reg(d, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host_bus_model.wr(a, d);
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic pulse(input int k);
		@(negedge sys_clk);
		{fs_tick, frame_start, instr_step} = 3'b001 << k;
		@(negedge sys_clk);
		{fs_tick, frame_start, instr_step} = 3'h0;
		@(negedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		rd_chk(ADDR_INSTR_MODE, RST_INSTR_MODE);
		rd_chk(ADDR_DMIC_POL, RST_DMIC_POL);
		rd_chk(ADDR_DIG_CTRL, RST_DIG_CTRL);
		rd_chk(ADDR_FINE_MUTE, RST_FINE_MUTE);
		rd_chk(ADDR_LEFT_VOL, RST_LEFT_VOL);
		$display("reset values done");
		rd_chk(8'h40, 8'h00);
		wr(ADDR_INSTR_MODE, 8'h70);
		rd_chk(ADDR_INSTR_MODE, 8'h70);
		chk_out(aux_a, 9'h1);
		chk_out(aux_b, 9'h1);
		sel = 5'h01;
		pulse(0);
		chk_out(aux_a, 9'h0);
		chk_out(aux_b, 9'h0);
		chk_out(count, 9'h0);
		sel = 5'h00;
		$display("flags done");
		repeat (3) pulse(0);
		chk_out(count, 9'h3);
		pulse(1);
		chk_out(count, 9'h3);
		wr(ADDR_INSTR_MODE, 8'h00);
		pulse(1);
		chk_out(count, 9'h0);
		$display("engine done");
		wr(ADDR_DIG_CTRL, 8'hc2);
		chk_out({lpw, rpw}, 9'h3);
		wr(ADDR_FINE_MUTE, 8'h71);
		chk_out({lmute, rmute, lfine, rfine}, 9'h021);
		wr(ADDR_FINE_MUTE, 8'hb2);
		rd_chk(ADDR_FINE_MUTE, 8'hb2);
		chk_out({lmute, rmute, lfine, rfine}, 9'h09a);
		rvol = VOL_MAX;
		wr(ADDR_LEFT_VOL, VOL_MIN);
		chk_out(lgain, VOL_MIN);
		chk_out(rgain, VOL_MAX);
		wr(ADDR_LEFT_VOL, 8'h00);
		wr(ADDR_DIG_CTRL, 8'hc0);
		wr(ADDR_LEFT_VOL, 8'h02);
		chk_out(lgain, 9'h0);
		pulse(2);
		chk_out(lgain, 9'h1);
		pulse(2);
		chk_out(lgain, 9'h2);
		wr(ADDR_DIG_CTRL, 8'hc1);
		wr(ADDR_LEFT_VOL, 8'h00);
		repeat (2) pulse(2);
		chk_out(lgain, 9'h1);
		$display("volume done");
		wr(ADDR_DMIC_POL, 8'h01);
		wr(ADDR_DIG_CTRL, 8'hde);
		dpin = 1'b1;
		mod_clk = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk_out({lcnt, lbit_seen}, 9'h003);
		chk_out(rcnt, 9'h0);
		cpin = 1'b1;
		@(negedge sys_clk);
		mod_clk = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk_out({rcnt, rbit_seen}, 9'h003);
		chk_out(lcnt, 9'h1);
		wr(ADDR_DIG_CTRL, 8'hd6);
		mod_clk = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk_out(lcnt, 9'h1);
		$display("microphone done");
		test_done();
	end
endmodule
`default_nettype wire
